/* inc/cctmr_pkg.sv */
`default_nettype none

package cctmr_pkg;

    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam int CHANNELS = 4;
    localparam int PRESCALE_W = 3;

    // Register word addresses.
    localparam logic [3:0] ADDR_MODE = 4'h0;
    localparam logic [3:0] ADDR_CTRL = 4'h1;
    localparam logic [3:0] ADDR_IRQEN = 4'h2;
    localparam logic [3:0] ADDR_STATUS = 4'h3;
    localparam logic [3:0] ADDR_IOCTL0 = 4'h4;
    localparam logic [3:0] ADDR_IOCTL1 = 4'h5;
    localparam logic [3:0] ADDR_COUNT = 4'h6;
    localparam logic [3:0] ADDR_GR_A = 4'h8;
    localparam logic [3:0] ADDR_GR_B = 4'h9;
    localparam logic [3:0] ADDR_GR_C = 4'hA;
    localparam logic [3:0] ADDR_GR_D = 4'hB;

    // Field positions.
    localparam int MODE_PWM_LSB = 0;
    localparam int MODE_BUF_A = 4;
    localparam int MODE_BUF_B = 5;
    localparam int MODE_COUNT_START = 7;
    localparam int CTRL_INIT_LSB = 0;
    localparam int CTRL_CKS_LSB = 4;
    localparam int CTRL_CLEAR_A = 7;
    localparam int FLAG_MATCH_LSB = 0;
    localparam int FLAG_OVF = 7;
    localparam int IOCTL_HI_LSB = 4;

    // Values after reset, and the counter maximum.
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] COUNT_MAX = 16'hFFFF;
    localparam logic [15:0] GR_RESET = 16'hFFFF;
    localparam logic [7:0] REG8_RESET = 8'h00;
    localparam logic [7:0] IOCTL_RESET = 8'h88;

    // Compare output actions and the undivided clock select.
    localparam logic [1:0] OUT_NONE = 2'h0;
    localparam logic [1:0] OUT_LOW = 2'h1;
    localparam logic [1:0] OUT_HIGH = 2'h2;
    localparam logic [1:0] OUT_TOGGLE = 2'h3;
    localparam logic [2:0] CKS_PHI = 3'h0;

    typedef struct packed {
        logic capture;
        logic [1:0] sel;
    } cctmr_ioctl_t;

    typedef struct packed {
        logic count_start;
        logic buffer_enable_b;
        logic buffer_enable_a;
        logic [2:0] pwm;
    } cctmr_mode_t;

endpackage : cctmr_pkg

`default_nettype wire

/* verilog/cctmr_timer.sv */
// Operation
// - Counter holds after reset, counting only once count start is set.
// - Wrap from FFFF to 0000 sets overflow flag; enabled flag requests interrupt.
// - Clear-on-match-A clears counter, sets match flag A, counting resumes.
// - Compare match drives pin low, high or toggles per its output field.
// - A pin already at the selected level stays unchanged at match.
// - Capture copies counter into its register on the selected pin edge.
// - Buffered capture A moves old register A into C, then stores counter.
// - PWM uses A as period, B/C/D duty, forces compare mode.
// - Initial-level 1: high at match A, low at duty match; 0 reverses.
// - PWM pins ignore compare output level selections.
// - Duty equal to period leaves that PWM output unchanged.
// - Buffered PWM B: each match B changes pin and loads B from D.
// - Match fires as counter leaves matching value; pin and flag follow.
// - Clear by match A with value N gives period N plus one.
// - A capture sets that channel's match flag.
// - Flag clears only by writing 0 after reading it as 1.
// - Clear beats counter write; counter write beats count-up.
// - Counter steps on rising edges of the selected clock: undivided, divided or external.
// - Initial levels set pins; control write beats a simultaneous match.
// - Output 00 none,01 low,10 high,11 toggle; capture 00 rise,01 fall,1X both.
// - Reset sets counter 0000, general registers FFFF; 16-bit access only.
// - C and D buffer A and B; compare match moves buffer into main.
`timescale 1ns/1ps
`default_nettype none

module cctmr_timer (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic [cctmr_pkg::ADDR_W-1:0] addr_in,
    input wire logic [cctmr_pkg::DATA_W-1:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [cctmr_pkg::CHANNELS-1:0] pin_in,
    input wire logic ext_clk_in,
    output logic [cctmr_pkg::CHANNELS-1:0] pin_out_out,
    output logic [cctmr_pkg::CHANNELS-1:0] pin_oe_out,
    output logic irq_out,
    output logic [cctmr_pkg::DATA_W-1:0] rdata_out
);

    logic [7:0] mode_r;
    logic [7:0] ctrl_r;
    logic [7:0] irqen_r;
    logic [7:0] ioctl0_r;
    logic [7:0] ioctl1_r;
    logic [4:0] flag_r;
    logic [4:0] arm_r;
    logic [15:0] cnt_r;
    logic [15:0] gr_r [cctmr_pkg::CHANNELS];
    logic [15:0] gr_nxt [cctmr_pkg::CHANNELS];
    logic [3:0] pin_r;
    logic [3:0] pin_nxt;
    logic [3:0] oe_r;
    logic irq_r;
    logic [15:0] rdata_r;
    logic [3:0] pin_s1_r;
    logic [3:0] pin_s2_r;
    logic [3:0] pin_s3_r;
    logic [2:0] ext_s_r;
    logic [cctmr_pkg::PRESCALE_W-1:0] div_r;
    logic div_lvl_r;
    logic div_lvl_r_d;

    cctmr_pkg::cctmr_mode_t mode;
    cctmr_pkg::cctmr_ioctl_t ioctl [cctmr_pkg::CHANNELS];
    logic [3:0] pwm_ch;
    logic [3:0] is_cap;
    logic [3:0] match;
    logic [3:0] cap_ev;
    logic [3:0] rise;
    logic [3:0] fall;
    logic [3:0] init_lvl;
    logic [2:0] cks;
    logic div_lvl;
    logic tick;
    logic clr_a;
    logic ovf_ev;
    logic [15:0] cnt_nxt;
    logic [4:0] flag_set;
    logic [4:0] flag_clr;
    logic [4:0] flag_nxt;
    logic [4:0] status_wdata;
    logic [15:0] rsel;

    wire wr_mode = wr_in && (addr_in == cctmr_pkg::ADDR_MODE);
    wire wr_ctrl = wr_in && (addr_in == cctmr_pkg::ADDR_CTRL);
    wire wr_irqen = wr_in && (addr_in == cctmr_pkg::ADDR_IRQEN);
    wire wr_status = wr_in && (addr_in == cctmr_pkg::ADDR_STATUS);
    wire wr_ioctl0 = wr_in && (addr_in == cctmr_pkg::ADDR_IOCTL0);
    wire wr_ioctl1 = wr_in && (addr_in == cctmr_pkg::ADDR_IOCTL1);
    wire wr_count = wr_in && (addr_in == cctmr_pkg::ADDR_COUNT);
    wire rd_status = rd_in && (addr_in == cctmr_pkg::ADDR_STATUS);
    wire wr_gr_any_addr = (addr_in[3:2] == cctmr_pkg::ADDR_GR_A[3:2]);
    wire [2:0] div_sel = {cks[1:0] == 2'h3, cks[1:0] == 2'h2, cks[1:0] == 2'h1};
    wire [3:0] wr_gr = {4{wr_in}} & {addr_in == cctmr_pkg::ADDR_GR_D,
        addr_in == cctmr_pkg::ADDR_GR_C, addr_in == cctmr_pkg::ADDR_GR_B,
        addr_in == cctmr_pkg::ADDR_GR_A};

    assign mode = {mode_r[cctmr_pkg::MODE_COUNT_START], mode_r[cctmr_pkg::MODE_BUF_B],
        mode_r[cctmr_pkg::MODE_BUF_A], mode_r[cctmr_pkg::MODE_PWM_LSB +: 3]};
    assign pwm_ch = {mode.pwm, 1'b0};
    assign init_lvl = ctrl_r[cctmr_pkg::CTRL_INIT_LSB +: 4];
    assign cks = ctrl_r[cctmr_pkg::CTRL_CKS_LSB +: 3];
    assign ioctl[0] = ioctl0_r[2:0];
    assign ioctl[1] = ioctl0_r[cctmr_pkg::IOCTL_HI_LSB +: 3];
    assign ioctl[2] = ioctl1_r[2:0];
    assign ioctl[3] = ioctl1_r[cctmr_pkg::IOCTL_HI_LSB +: 3];

    // A switch between divided clocks can look like a rising edge and add a count.
    assign div_lvl = cks[2] ? ext_s_r[1] : div_lvl_r;
    assign tick = mode.count_start && ((cks == cctmr_pkg::CKS_PHI) || (div_lvl && !(cks[2] ?
        ext_s_r[2] : div_lvl_r_d)));

    // A match is taken as the counter leaves the matching value.
    assign clr_a = match[0] && ctrl_r[cctmr_pkg::CTRL_CLEAR_A];
    assign ovf_ev = tick && (cnt_r == cctmr_pkg::COUNT_MAX) && !clr_a;
    // The clear wins over a counter write, the write over a count-up.
    assign cnt_nxt = clr_a ? cctmr_pkg::COUNT_RESET :
        wr_count ? wdata_in :
        tick ? 16'(cnt_r + 16'h0001) : cnt_r;

    genvar i;
    generate
        for (i = 0; i < cctmr_pkg::CHANNELS; i++)
        begin : g_ch
            wire both = ioctl[i].sel[1];
            wire same_period = (gr_r[i] == gr_r[0]);
            logic pin_calc;
            // Any PWM pin also forces the period register into compare mode.
            if (i == 0)
            begin : g_a
                assign is_cap[i] = ioctl[i].capture && !(|mode.pwm);
            end
            else
            begin : g_bcd
                assign is_cap[i] = ioctl[i].capture && !pwm_ch[i];
            end
            assign match[i] = tick && !is_cap[i] && (cnt_r == gr_r[i]);
            assign rise[i] = pin_s2_r[i] && !pin_s3_r[i];
            assign fall[i] = !pin_s2_r[i] && pin_s3_r[i];
            assign cap_ev[i] = is_cap[i] && (both ? (rise[i] || fall[i]) :
                (ioctl[i].sel[0] ? fall[i] : rise[i]));

            always_comb
            begin
                pin_calc = pin_r[i];
                if (pwm_ch[i])
                begin
                    // Equal duty and period would fight, so the pin just holds.
                    if (!same_period)
                    begin
                        if (match[0])
                            pin_calc = init_lvl[i];
                        else if (match[i])
                            pin_calc = !init_lvl[i];
                    end
                end
                else if (match[i])
                begin
                    case (ioctl[i].sel)
                        cctmr_pkg::OUT_LOW: pin_calc = 1'b0;
                        cctmr_pkg::OUT_HIGH: pin_calc = 1'b1;
                        cctmr_pkg::OUT_TOGGLE: pin_calc = !pin_r[i];
                        default: pin_calc = pin_r[i];
                    endcase
                end
            end
            // A control write reloads initial levels and drops the match change.
            assign pin_nxt[i] = wr_ctrl ? wdata_in[cctmr_pkg::CTRL_INIT_LSB + i] : pin_calc;

            if (i < 2)
            begin : g_main
                wire buf_en = (i == 0) ? mode.buffer_enable_a : mode.buffer_enable_b;
                assign gr_nxt[i] = cap_ev[i] ? cnt_r :
                    (match[i] && buf_en) ? gr_r[i+2] :
                    wr_gr[i] ? wdata_in : gr_r[i];
            end
            else
            begin : g_buf
                wire buf_en = (i == 2) ? mode.buffer_enable_a : mode.buffer_enable_b;
                assign gr_nxt[i] = (cap_ev[i-2] && buf_en) ? gr_r[i-2] :
                    cap_ev[i] ? cnt_r :
                    wr_gr[i] ? wdata_in : gr_r[i];
            end
        end
    endgenerate

    assign status_wdata = {wdata_in[cctmr_pkg::FLAG_OVF], wdata_in[cctmr_pkg::FLAG_MATCH_LSB +: 4]};
    assign flag_set = {ovf_ev, match | cap_ev};
    assign flag_clr = {5{wr_status}} & arm_r & ~status_wdata;
    // A new event wins over a clear in the same cycle.
    assign flag_nxt = flag_set | (flag_r & ~flag_clr);

    always_comb
    begin
        rsel = 16'h0000;
        if (addr_in == cctmr_pkg::ADDR_MODE)
            rsel = {8'h00, mode_r};
        else if (addr_in == cctmr_pkg::ADDR_CTRL)
            rsel = {8'h00, ctrl_r};
        else if (addr_in == cctmr_pkg::ADDR_IRQEN)
            rsel = {8'h00, irqen_r};
        else if (addr_in == cctmr_pkg::ADDR_STATUS)
            rsel = {8'h00, flag_r[4], 3'h0, flag_r[3:0]};
        else if (addr_in == cctmr_pkg::ADDR_IOCTL0)
            rsel = {8'h00, ioctl0_r};
        else if (addr_in == cctmr_pkg::ADDR_IOCTL1)
            rsel = {8'h00, ioctl1_r};
        else if (addr_in == cctmr_pkg::ADDR_COUNT)
            rsel = cnt_r;
        else if (wr_gr_any_addr)
            rsel = gr_r[addr_in[1:0]];
    end

    always_ff @(posedge clk_in)
    begin
        if (!reset_n_in)
        begin
            mode_r <= cctmr_pkg::REG8_RESET;
            ctrl_r <= cctmr_pkg::REG8_RESET;
            irqen_r <= cctmr_pkg::REG8_RESET;
            ioctl0_r <= cctmr_pkg::IOCTL_RESET;
            ioctl1_r <= cctmr_pkg::IOCTL_RESET;
            cnt_r <= cctmr_pkg::COUNT_RESET;
            flag_r <= 5'h00;
            arm_r <= 5'h00;
        end
        else
        begin
            if (wr_mode)
                mode_r <= {wdata_in[7], 1'b0, wdata_in[5:4], 1'b0, wdata_in[2:0]};
            if (wr_ctrl)
                ctrl_r <= wdata_in[7:0];
            if (wr_irqen)
                irqen_r <= {wdata_in[7], 3'h0, wdata_in[3:0]};
            if (wr_ioctl0)
                ioctl0_r <= wdata_in[7:0] | cctmr_pkg::IOCTL_RESET;
            if (wr_ioctl1)
                ioctl1_r <= wdata_in[7:0] | cctmr_pkg::IOCTL_RESET;
            cnt_r <= cnt_nxt;
            flag_r <= flag_nxt;
            arm_r <= wr_status ? 5'h00 : (arm_r | ({5{rd_status}} & flag_r));
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (!reset_n_in)
        begin
            for (int k = 0; k < cctmr_pkg::CHANNELS; k++)
                gr_r[k] <= cctmr_pkg::GR_RESET;
            pin_r <= 4'h0;
            oe_r <= 4'h0;
            irq_r <= 1'b0;
            rdata_r <= 16'h0000;
        end
        else
        begin
            for (int k = 0; k < cctmr_pkg::CHANNELS; k++)
                gr_r[k] <= gr_nxt[k];
            pin_r <= pin_nxt;
            oe_r <= ~is_cap;
            irq_r <= |(flag_nxt & {irqen_r[cctmr_pkg::FLAG_OVF], irqen_r[3:0]});
            rdata_r <= rd_in ? rsel : 16'h0000;
        end
    end

    // Two stages before any edge logic; narrower pulses can be missed.
    always_ff @(posedge clk_in)
    begin
        if (!reset_n_in)
        begin
            pin_s1_r <= 4'h0;
            pin_s2_r <= 4'h0;
            pin_s3_r <= 4'h0;
            ext_s_r <= 3'h0;
            div_r <= '0;
            div_lvl_r <= 1'b0;
            div_lvl_r_d <= 1'b0;
        end
        else
        begin
            pin_s1_r <= pin_in;
            pin_s2_r <= pin_s1_r;
            pin_s3_r <= pin_s2_r;
            ext_s_r <= {ext_s_r[1], ext_s_r[0], ext_clk_in};
            div_r <= div_r + 1'b1;
            // A one-hot tap select keeps the index in range for every clock select.
            div_lvl_r <= |(div_r & div_sel);
            div_lvl_r_d <= div_lvl_r;
        end
    end

    assign pin_out_out = pin_r;
    assign pin_oe_out = oe_r;
    assign irq_out = irq_r;
    assign rdata_out = rdata_r;

    a_overflow_set: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        ovf_ev |=> flag_r[4])
        else $error("overflow flag not set on wrap");

    a_clear_on_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        clr_a |=> (cnt_r == 16'h0000) && flag_r[0])
        else $error("match A did not clear counter and set flag");

    a_stopped_hold: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (!mode.count_start && !wr_count) |=> $stable(cnt_r))
        else $error("counter moved while stopped");

    a_count_step: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (tick && !clr_a && !wr_count) |=> cnt_r == 16'($past(cnt_r) + 16'h0001))
        else $error("counter did not step by one");

    a_capture_value: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (cap_ev[1]) |=> gr_r[1] == $past(cnt_r))
        else $error("capture B stored wrong value");

    a_buffer_capture: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (cap_ev[0] && mode.buffer_enable_a) |=> (gr_r[2] == $past(gr_r[0]))
        && (gr_r[0] == $past(cnt_r)))
        else $error("buffered capture A order wrong");

    a_flag_clear_read: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        $fell(flag_r[1]) |-> $past(arm_r[1]) && $past(wr_status))
        else $error("flag B cleared without read then write");

    a_ctrl_write_wins: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        wr_ctrl |=> pin_out_out == $past(wdata_in[3:0]))
        else $error("control write did not set pin levels");

    a_pwm_period_level: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (pwm_ch[1] && match[0] && (gr_r[1] != gr_r[0]) && !wr_ctrl)
        |=> pin_out_out[1] == $past(init_lvl[1]))
        else $error("PWM B wrong level at period match");

    a_pwm_duty_level: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (pwm_ch[1] && match[1] && !match[0] && (gr_r[1] != gr_r[0]) && !wr_ctrl)
        |=> pin_out_out[1] == !$past(init_lvl[1]))
        else $error("PWM B wrong level at duty match");

    a_duty_equal_hold: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (pwm_ch[2] && (gr_r[2] == gr_r[0]) && !wr_ctrl) |=> $stable(pin_out_out[2]))
        else $error("PWM C moved with duty equal to period");

    a_pin_low_match: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (match[1] && !pwm_ch[1] && !wr_ctrl && (ioctl[1].sel == cctmr_pkg::OUT_LOW))
        |=> !pin_out_out[1])
        else $error("pin B not driven low at match");

    a_write_beats_count: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (wr_count && !clr_a) |=> cnt_r == $past(wdata_in))
        else $error("counter write lost");

    a_capture_flag: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        cap_ev[0] |=> flag_r[0])
        else $error("capture A did not set its flag");

    a_overflow_irq: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (flag_nxt[4] && irqen_r[cctmr_pkg::FLAG_OVF]) |=> irq_out)
        else $error("enabled overflow flag raised no request");

    a_buffer_compare: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (match[1] && mode.buffer_enable_b && !cap_ev[1]) |=> gr_r[1] == $past(gr_r[3]))
        else $error("match B did not load register B from D");

    a_match_flag_set: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        flag_set[1] |=> flag_r[1])
        else $error("flag B not set by its event");

endmodule : cctmr_timer

`default_nettype wire

/* verilog/cctmr_unused_note_placeholder.sv */
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

/* bench/cctmr_pin_model.sv */
`timescale 1ns/1ps
`default_nettype none

module cctmr_pin_model (
    input wire logic [cctmr_pkg::CHANNELS-1:0] drive_lvl_in,
    input wire logic [cctmr_pkg::CHANNELS-1:0] pin_out_in,
    input wire logic [cctmr_pkg::CHANNELS-1:0] pin_oe_in,
    output logic [cctmr_pkg::CHANNELS-1:0] pin_level_out
);
    // A pin that the timer drives reads back its own level; otherwise the source owns it.
    // The source holds each level for many clocks, far above the two-clock minimum.
    assign pin_level_out = (pin_oe_in & pin_out_in) | (~pin_oe_in & drive_lvl_in);
endmodule : cctmr_pin_model

`default_nettype wire

/* bench/tb_cctmr_timer.sv */
`timescale 1ns/1ps
`default_nettype none

module tb_cctmr_timer;
    logic clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic [3:0] addr_in = 4'h0;
    logic [15:0] wdata_in = 16'h0000;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic [3:0] drive_lvl = 4'h0;
    logic ext_clk = 1'b0;
    logic [3:0] pin_in;
    logic [3:0] pin_out_out;
    logic [3:0] pin_oe_out;
    logic irq_out;
    logic [15:0] rdata_out;
    logic [15:0] rv;
    logic [15:0] n;
    int n_errors = 0;
    int samples_checked = 0;

    always #20 clk_in = ~clk_in;

    cctmr_timer u_cctmr_timer (
        .clk_in(clk_in), .reset_n_in(reset_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
        .wr_in(wr_in), .rd_in(rd_in), .pin_in(pin_in), .ext_clk_in(ext_clk),
        .pin_out_out(pin_out_out), .pin_oe_out(pin_oe_out), .irq_out(irq_out),
        .rdata_out(rdata_out)
    );

    cctmr_pin_model u_cctmr_pin_model (
        .drive_lvl_in(drive_lvl), .pin_out_in(pin_out_out), .pin_oe_in(pin_oe_out),
        .pin_level_out(pin_in)
    );

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : final_report

    task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe, so they are taken 1 ns into it.
    task automatic rd(input logic [3:0] a);
        @(posedge clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1;
        rv = rdata_out;
    endtask : rd

    task automatic cyc(input int k);
        repeat (k) @(posedge clk_in);
    endtask : cyc

    task automatic gap(input int b);
        logic p;
        p = pin_out_out[b];
        n = 16'h0000;
        while (pin_out_out[b] === p)
        begin
            @(posedge clk_in);
            #1;
            n = n + 16'h0001;
            if (n > 16'h0032)
            begin
                chk("pin edge wait", n, 16'h0000);
                final_report();
            end
        end
    endtask : gap

    task automatic hi_count(input int b);
        n = 16'h0000;
        repeat (20)
        begin
            @(posedge clk_in);
            #1;
            if (pin_out_out[b] === 1'b1)
                n = n + 16'h0001;
        end
    endtask : hi_count

    task automatic test_reset;
        rd(cctmr_pkg::ADDR_COUNT);
        chk("counter", rv, 16'h0000);
        for (int i = 0; i < 4; i++)
        begin
            rd(4'(cctmr_pkg::ADDR_GR_A + i));
            chk("general reg", rv, 16'hFFFF);
        end
        rd(cctmr_pkg::ADDR_IOCTL0);
        chk("io control 0", rv, 16'h0088);
        rd(4'h7);
        chk("unmapped", rv, 16'h0000);
        cyc(4);
        rd(cctmr_pkg::ADDR_COUNT);
        chk("counter idle", rv, 16'h0000);
        chk("pin oe", {12'h000, pin_oe_out}, 16'h000F);
        $display("test reset done");
    endtask : test_reset

    task automatic test_period;
        wr(cctmr_pkg::ADDR_GR_A, 16'h0004);
        wr(cctmr_pkg::ADDR_IOCTL0, 16'h0003);
        wr(cctmr_pkg::ADDR_CTRL, 16'h0080);
        wr(cctmr_pkg::ADDR_MODE, 16'h0080);
        gap(0);
        gap(0);
        chk("period a", n, 16'h0005);
        rd(cctmr_pkg::ADDR_STATUS);
        chk("match flag a", rv & 16'h0001, 16'h0001);
        wr(cctmr_pkg::ADDR_MODE, 16'h0000);
        wr(cctmr_pkg::ADDR_STATUS, 16'hFFFF);
        wr(cctmr_pkg::ADDR_STATUS, 16'h0000);
        rd(cctmr_pkg::ADDR_STATUS);
        chk("flag kept", rv & 16'h0001, 16'h0001);
        wr(cctmr_pkg::ADDR_STATUS, 16'h0000);
        rd(cctmr_pkg::ADDR_STATUS);
        chk("flag cleared", rv & 16'h0001, 16'h0000);
        $display("test period done");
    endtask : test_period

    task automatic test_outputs;
        logic [1:0] sel;
        for (int i = 0; i < 4; i++)
        begin
            sel = 2'(i + 1);
            wr(cctmr_pkg::ADDR_MODE, 16'h0000);
            wr(cctmr_pkg::ADDR_COUNT, 16'h0000);
            wr(cctmr_pkg::ADDR_CTRL, 16'h0002);
            wr(cctmr_pkg::ADDR_IOCTL0, 16'(sel) << 4);
            wr(cctmr_pkg::ADDR_GR_B, 16'h0003);
            wr(cctmr_pkg::ADDR_MODE, 16'h0080);
            cyc(8);
            chk("pin b", 16'(pin_out_out[1]),
                16'(sel == cctmr_pkg::OUT_HIGH || sel == cctmr_pkg::OUT_NONE));
        end
        $display("test outputs done");
    endtask : test_outputs

    task automatic test_overflow;
        wr(cctmr_pkg::ADDR_MODE, 16'h0000);
        wr(cctmr_pkg::ADDR_IRQEN, 16'h0080);
        wr(cctmr_pkg::ADDR_COUNT, 16'hFFFD);
        wr(cctmr_pkg::ADDR_MODE, 16'h0080);
        cyc(6);
        rd(cctmr_pkg::ADDR_STATUS);
        chk("overflow flag", rv & 16'h0080, 16'h0080);
        chk("irq", 16'(irq_out), 16'h0001);
        wr(cctmr_pkg::ADDR_IRQEN, 16'h0000);
        cyc(2);
        chk("irq masked", 16'(irq_out), 16'h0000);
        $display("test overflow done");
    endtask : test_overflow

    task automatic test_capture;
        wr(cctmr_pkg::ADDR_MODE, 16'h0000);
        // Match the source to the driven level first so the hand-over makes no edge.
        drive_lvl <= pin_out_out;
        wr(cctmr_pkg::ADDR_IOCTL0, 16'h0046);
        wr(cctmr_pkg::ADDR_MODE, 16'h0010);
        drive_lvl[1] <= 1'b1;
        cyc(6);
        chk("capture oe", 16'(pin_oe_out[1:0]), 16'h0000);
        wr(cctmr_pkg::ADDR_GR_A, 16'h1111);
        wr(cctmr_pkg::ADDR_GR_B, 16'h2222);
        wr(cctmr_pkg::ADDR_COUNT, 16'h0ABC);
        rd(cctmr_pkg::ADDR_STATUS);
        wr(cctmr_pkg::ADDR_STATUS, 16'h0000);
        drive_lvl[0] <= ~drive_lvl[0];
        drive_lvl[1] <= 1'b0;
        cyc(6);
        rd(cctmr_pkg::ADDR_GR_A);
        chk("capture a", rv, 16'h0ABC);
        rd(cctmr_pkg::ADDR_GR_C);
        chk("buffer c", rv, 16'h1111);
        rd(cctmr_pkg::ADDR_GR_B);
        chk("no capture b", rv, 16'h2222);
        rd(cctmr_pkg::ADDR_STATUS);
        chk("flag a", rv & 16'h0003, 16'h0001);
        wr(cctmr_pkg::ADDR_COUNT, 16'h0DEF);
        drive_lvl[0] <= ~drive_lvl[0];
        drive_lvl[1] <= 1'b1;
        cyc(6);
        rd(cctmr_pkg::ADDR_GR_A);
        chk("capture a 2", rv, 16'h0DEF);
        rd(cctmr_pkg::ADDR_GR_C);
        chk("buffer c 2", rv, 16'h0ABC);
        rd(cctmr_pkg::ADDR_GR_B);
        chk("capture b", rv, 16'h0DEF);
        wr(cctmr_pkg::ADDR_IOCTL0, 16'h0056);
        wr(cctmr_pkg::ADDR_COUNT, 16'h0123);
        drive_lvl[1] <= 1'b0;
        cyc(6);
        rd(cctmr_pkg::ADDR_GR_B);
        chk("capture b fall", rv, 16'h0123);
        $display("test capture done");
    endtask : test_capture

    task automatic test_pwm;
        wr(cctmr_pkg::ADDR_MODE, 16'h0000);
        wr(cctmr_pkg::ADDR_IOCTL0, 16'h0010);
        wr(cctmr_pkg::ADDR_IOCTL1, 16'h0000);
        wr(cctmr_pkg::ADDR_GR_A, 16'h0009);
        wr(cctmr_pkg::ADDR_GR_B, 16'h0003);
        wr(cctmr_pkg::ADDR_GR_C, 16'h0009);
        wr(cctmr_pkg::ADDR_COUNT, 16'h0000);
        wr(cctmr_pkg::ADDR_CTRL, 16'h0086);
        wr(cctmr_pkg::ADDR_MODE, 16'h0083);
        cyc(12);
        hi_count(1);
        chk("pwm b high", n, 16'h0008);
        hi_count(2);
        chk("pwm c high", n, 16'h0014);
        wr(cctmr_pkg::ADDR_CTRL, 16'h0084);
        cyc(12);
        hi_count(1);
        chk("pwm b low init", n, 16'h000C);
        wr(cctmr_pkg::ADDR_GR_D, 16'h0005);
        wr(cctmr_pkg::ADDR_MODE, 16'h00A3);
        cyc(25);
        rd(cctmr_pkg::ADDR_GR_B);
        chk("duty from d", rv, 16'h0005);
        hi_count(1);
        chk("pwm b buffered", n, 16'h0008);
        $display("test pwm done");
    endtask : test_pwm

    // Reads 64 cycles apart see exactly eight ticks of the divide-by-8 clock.
    task automatic test_clock;
        logic [15:0] c0;
        wr(cctmr_pkg::ADDR_MODE, 16'h0000);
        wr(cctmr_pkg::ADDR_CTRL, 16'h0030);
        wr(cctmr_pkg::ADDR_MODE, 16'h0080);
        rd(cctmr_pkg::ADDR_COUNT);
        c0 = rv;
        cyc(62);
        rd(cctmr_pkg::ADDR_COUNT);
        chk("divide by 8", 16'(rv - c0), 16'h0008);
        wr(cctmr_pkg::ADDR_MODE, 16'h0000);
        wr(cctmr_pkg::ADDR_CTRL, 16'h0040);
        wr(cctmr_pkg::ADDR_MODE, 16'h0080);
        rd(cctmr_pkg::ADDR_COUNT);
        c0 = rv;
        repeat (5)
        begin
            ext_clk <= 1'b1;
            cyc(2);
            ext_clk <= 1'b0;
            cyc(2);
        end
        cyc(4);
        rd(cctmr_pkg::ADDR_COUNT);
        chk("external count", 16'(rv - c0), 16'h0005);
        $display("test clock done");
    endtask : test_clock

    initial
    begin
        cyc(6);
        reset_n_in <= 1'b1;
        test_reset();
        test_period();
        test_outputs();
        test_overflow();
        test_capture();
        test_pwm();
        test_clock();
        final_report();
    end
endmodule : tb_cctmr_timer

`default_nettype wire
